// >>> logic/tic_pkg.sv
// Purpose: constants for the timer input conditioning block
// Assumes: 16-bit register port, byte addresses on a 24-bit address
// Notes: bit n below means bit n of the 16-bit data word, bit 0 = lsb
//
// Contract
// - input 11 selector in bits 5-7 of ctrl_b, codes 000 to 111
// - three-bit codes 10x mean low level, 11x mean high level
// - input 10 selector in bits 9-11 of ctrl_b, same encoding
// - input 9 selector in bits 13-15 of ctrl_b, same encoding
// - inputs 19 down to 12 use bit pairs 0-1 up to 14-15 of ctrl_c
// - two-bit codes ignore, rising, falling, both; no level sensing
// - inputs 23 down to 20 use bit pairs 8-9 up to 14-15 of ctrl_d
// - ctrl_b and ctrl_c clear to zero on reset
// - ctrl_d clears to zero on reset
package tic_pkg;

    // =========================================================
    // address map
    localparam int ADDR_W = 24;
    localparam logic [23:0] OFS_CTRL_B = 24'h800216;
    localparam logic [23:0] OFS_CTRL_C = 24'h800218;
    localparam logic [23:0] OFS_CTRL_D = 24'h80021B;
    localparam logic [23:0] OFS_PIN_STAT = 24'h80021C;

    // =========================================================
    // reset values and masks
    localparam logic [15:0] RST_CTRL_B = 16'h0000;
    localparam logic [15:0] RST_CTRL_C = 16'h0000;
    localparam logic [7:0] RST_CTRL_D = 8'h00;
    localparam logic [15:0] MASK_CTRL_B = 16'hEEE0;
    localparam logic [15:0] RD_ZERO = 16'h0000;

    // =========================================================
    // input numbering and field layout
    localparam int IN_LO = 9;
    localparam int IN_HI = 23;
    localparam int IN_WIDE_HI = 11;
    localparam int IN_C_HI = 19;
    localparam int B_LSB_TOP = 5;
    localparam int B_STEP = 4;
    localparam int C_STEP = 2;
    localparam int D_STEP = 2;
    localparam int D_LANE = 8;
    localparam int STAT_LSB = 1;

    // =========================================================
    // selector codes, two-bit codes sit in the low bits
    localparam logic [2:0] SEL_OFF = 3'h0;
    localparam logic [2:0] SEL_RISE = 3'h1;
    localparam logic [2:0] SEL_FALL = 3'h2;
    localparam logic [2:0] SEL_BOTH = 3'h3;
    localparam logic [1:0] SEL_LVL_LOW = 2'h2;
    localparam logic [1:0] SEL_LVL_HIGH = 2'h3;

endpackage

// >>> logic/tic_top.sv
// Purpose: conditions timer inputs 9 to 23 into events or levels
// Assumes: pins are asynchronous to core_clk; one clock domain
// Notes: read data appear in the cycle after the read strobe only
module tic_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [23:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // timer input pins
    input wire logic [23:9] timer_in,
    // conditioned outputs to the timers
    output logic [23:9] tin_event,
    output logic [23:9] tin_level
);

    // =========================================================
    // behaviour notes
    //
    // register side
    // - all registers are reached by full 24-bit address compare
    // - a write lands at the edge that samples the write strobe
    // - selectors act from the cycle after that edge
    // - read data stand for one cycle after the read strobe
    // - outside that cycle the read data are zero
    // - the slave never stalls; strobes may come back to back
    // - ctrl_d is a byte register carried on the upper data lane
    // - the lower byte of a ctrl_d read is always zero
    // - unassigned ctrl_b bits are masked on write and on read
    // - unmapped addresses ignore writes and read zero
    // - the pin status word is read only, input 9 at bit 1
    //
    // pin side
    // - every pin passes two flops before any logic reads it
    // - a third flop holds the previous synchronised level
    // - an edge is a difference between that pair of flops
    // - a pin change shows at the outputs two edges after capture
    // - pulses shorter than one clock may be lost entirely
    // - edges one cycle apart each give their own event pulse
    //
    // treatment
    // - off codes give neither events nor levels
    // - rise, fall and both codes give one-cycle event pulses
    // - level codes give no events, only a held level indication
    // - the lsb of a level code has no effect
    // - only inputs 9 to 11 can reach the level codes
    // - inputs 12 to 23 pad their two-bit code with a zero msb
    //
    // hazards
    // - history flops clear on reset, so a pin that idles high
    //   looks like a rising edge two cycles after release
    // - selectors are zero then unless a write lands at the first two edges after release, so that edge goes unreported
    // - changing a selector while a pin moves may drop one edge
    // - level outputs follow the pin with the same two-cycle lag
    //
    // =========================================================
    // decode helpers

    // true when the address selects the given register
    function automatic logic hit(input logic [23:0] a,
                                 input logic [23:0] ofs);
        hit = (a == ofs);
    endfunction

    // turns a three-bit code and the sampled pin into event and level
    function automatic logic [1:0] treat(input logic [2:0] code,
                                         input logic cur,
                                         input logic prev);
        logic ev;
        logic lv;
        ev = 1'b0;
        lv = 1'b0;
        if (code[2]) begin
            // level codes ignore the lsb
            if (code[2:1] == tic_pkg::SEL_LVL_HIGH) begin
                lv = cur;
            end else begin
                lv = ~cur;
            end
        end else begin
            unique case (code)
                tic_pkg::SEL_OFF: begin
                    ev = 1'b0;
                end
                tic_pkg::SEL_RISE: begin
                    ev = cur & ~prev;
                end
                tic_pkg::SEL_FALL: begin
                    ev = ~cur & prev;
                end
                tic_pkg::SEL_BOTH: begin
                    ev = cur ^ prev;
                end
            endcase
        end
        treat = {ev, lv};
    endfunction

    // =========================================================
    // address decode

    logic sel_b;
    logic sel_c;
    logic sel_d;
    logic sel_stat;

    // register selects shared by the write and read paths
    always_comb begin
        sel_b = hit(reg_addr, tic_pkg::OFS_CTRL_B);
        sel_c = hit(reg_addr, tic_pkg::OFS_CTRL_C);
        sel_d = hit(reg_addr, tic_pkg::OFS_CTRL_D);
        sel_stat = hit(reg_addr, tic_pkg::OFS_PIN_STAT);
    end

    // =========================================================
    // control registers

    logic [15:0] ctrl_b_q;
    logic [15:0] ctrl_b_d;
    logic [15:0] ctrl_c_q;
    logic [15:0] ctrl_c_d;
    logic [7:0] ctrl_d_q;
    logic [7:0] ctrl_d_d;

    // next values on a write strobe
    always_comb begin
        ctrl_b_d = ctrl_b_q;
        ctrl_c_d = ctrl_c_q;
        ctrl_d_d = ctrl_d_q;
        if (reg_wr) begin
            if (sel_b) begin
                // unassigned bits stay zero
                ctrl_b_d = reg_wdata & tic_pkg::MASK_CTRL_B;
            end
            if (sel_c) begin
                ctrl_c_d = reg_wdata;
            end
            if (sel_d) begin
                // byte register rides the upper lane
                ctrl_d_d = reg_wdata[15:tic_pkg::D_LANE];
            end
        end
    end

    // register the control state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_b_q <= tic_pkg::RST_CTRL_B;
            ctrl_c_q <= tic_pkg::RST_CTRL_C;
            ctrl_d_q <= tic_pkg::RST_CTRL_D;
        end else begin
            ctrl_b_q <= ctrl_b_d;
            ctrl_c_q <= ctrl_c_d;
            ctrl_d_q <= ctrl_d_d;
        end
    end

    // =========================================================
    // pin synchronisers and edge history

    logic [23:9] meta_q;
    logic [23:9] meta_d;
    logic [23:9] sync_q;
    logic [23:9] sync_d;
    logic [23:9] prev_q;
    logic [23:9] prev_d;

    // two flops per pin, then one stage of history
    always_comb begin
        meta_d = timer_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // register the pin stages
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // =========================================================
    // per-input selector extraction and treatment

    logic [2:0] sel [23:9];
    logic [23:9] ev_w;
    logic [23:9] lv_w;

    genvar gi;
    generate
        for (gi = tic_pkg::IN_LO; gi <= tic_pkg::IN_HI; gi++) begin : g_in
            if (gi <= tic_pkg::IN_WIDE_HI) begin : g_wide
                localparam int LSB = tic_pkg::B_LSB_TOP
                    + tic_pkg::B_STEP * (tic_pkg::IN_WIDE_HI - gi);
                // three-bit selectors of inputs 9 to 11
                assign sel[gi] = ctrl_b_q[LSB+2:LSB];
            end else if (gi <= tic_pkg::IN_C_HI) begin : g_mid
                localparam int LSB = tic_pkg::C_STEP
                    * (tic_pkg::IN_C_HI - gi);
                // two-bit selectors, level codes unreachable
                assign sel[gi] = {1'b0, ctrl_c_q[LSB+1:LSB]};
            end else begin : g_top
                localparam int LSB = tic_pkg::D_STEP
                    * (tic_pkg::IN_HI - gi);
                // two-bit selectors of inputs 20 to 23
                assign sel[gi] = {1'b0, ctrl_d_q[LSB+1:LSB]};
            end
            // event and level for this input
            assign {ev_w[gi], lv_w[gi]} =
                treat(sel[gi], sync_q[gi], prev_q[gi]);
        end
    endgenerate

    // =========================================================
    // conditioned outputs

    logic [23:9] event_q;
    logic [23:9] event_d;
    logic [23:9] level_q;
    logic [23:9] level_d;

    // next output values
    always_comb begin
        event_d = ev_w; // one-cycle pulse per qualifying edge
        level_d = lv_w; // held while the level is active
    end

    // register the outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_q <= '0;
            level_q <= '0;
        end else begin
            event_q <= event_d;
            level_q <= level_d;
        end
    end

    assign tin_event = event_q;
    assign tin_level = level_q;

    // =========================================================
    // read path

    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [15:0] pin_stat;

    // synchronised pin levels, input 9 at bit 1
    assign pin_stat = {sync_q, 1'b0};

    // data stand only in the cycle after the read strobe
    always_comb begin
        rdata_d = tic_pkg::RD_ZERO;
        if (reg_rd) begin
            if (sel_b) begin
                rdata_d = ctrl_b_q & tic_pkg::MASK_CTRL_B;
            end else if (sel_c) begin
                rdata_d = ctrl_c_q;
            end else if (sel_d) begin
                rdata_d = {ctrl_d_q, tic_pkg::RST_CTRL_D};
            end else if (sel_stat) begin
                rdata_d = pin_stat;
            end else begin
                rdata_d = tic_pkg::RD_ZERO; // unmapped reads zero
            end
        end
    end

    // register the read data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= tic_pkg::RD_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

// >>> verif/tic_pin_model.sv
// Purpose: far-side model of the timer input pins
// Assumes: pins move just after a rising edge
// Notes: no glitches; pins are always driven
module tic_pin_model (
    // clock
    input wire logic core_clk,
    // wanted pin levels
    input wire logic [23:9] pin_cmd,
    // pins into the block
    output logic [23:9] timer_in
);
    // ====
    // pins follow the wanted levels one cycle late
    always @(posedge core_clk) begin
        timer_in <= pin_cmd;
    end
endmodule

// >>> verif/tic_top_monitor.sv
// Purpose: port checks for tic_top
// Assumes: one clock, async active-low reset
// Notes: shadows ctrl_b writes to know selectors
module tic_top_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [23:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // pins and outputs
    input wire logic [23:9] timer_in,
    input wire logic [23:9] tin_event,
    input wire logic [23:9] tin_level
);
    logic [15:0] b_d;
    logic [15:0] b_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ====
    // shadow of ctrl_b
    always_comb begin
        b_d = b_q;
        if (reg_wr && reg_addr == tic_pkg::OFS_CTRL_B) b_d = reg_wdata;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) b_q <= 16'h0000;
        else b_q <= b_d;
    end
    // ====
    // properties
    property p_rd_b; reg_rd && reg_addr == tic_pkg::OFS_CTRL_B
        |=> reg_rdata == ($past(b_q) & tic_pkg::MASK_CTRL_B); endproperty
    a_rd_b: assert property (p_rd_b) else $error("ctrl_b read");
    property p_unmap; reg_rd && reg_addr == 24'h80021A
        |=> reg_rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_hi_lvl; tin_level[23:12] == 12'h000; endproperty
    a_hi_lvl: assert property (p_hi_lvl) else $error("level");
    property p_quiet; $stable(timer_in)[*3] |=> tin_event == 15'h0000;
    endproperty
    a_quiet: assert property (p_quiet) else $error("event");
    property p_lvl9; (b_q[15:14] == 2'h3 && timer_in[9])[*4]
        |=> tin_level[9]; endproperty
    a_lvl9: assert property (p_lvl9) else $error("level 9");
    property p_off9; b_q[15:13] == 3'h0 && $past(b_q[15:13]) == 3'h0
        |-> !tin_event[9] && !tin_level[9]; endproperty
    a_off9: assert property (p_off9) else $error("off 9");
    property p_rise11; tin_event[11] && $past(b_q[7:5]) == 3'h1
        |-> $past(timer_in[11], 3); endproperty
    a_rise11: assert property (p_rise11) else $error("rise");
    property p_fall10; tin_event[10] && $past(b_q[11:9]) == 3'h2
        |-> !$past(timer_in[10], 3); endproperty
    a_fall10: assert property (p_fall10) else $error("fall");
endmodule

bind tic_top tic_top_monitor tic_top_monitor_inst (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_in(timer_in), .tin_event(tin_event), .tin_level(tin_level));

// >>> verif/tb_top.sv
// Purpose: register and pin tests for tic_top
// Assumes: fixed read latency of one cycle
// Notes: each selector is set alone to catch field swaps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [23:0] reg_addr = 24'h000000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [23:9] pin_cmd = 15'h0000;
    logic [23:9] timer_in;
    logic [23:9] tin_event;
    logic [23:9] tin_level;
    int bad_count = 0;
    int comparisons = 0;
    always #50 core_clk = ~core_clk;
    tic_pin_model tic_pin_model_inst (.core_clk(core_clk),
        .pin_cmd(pin_cmd), .timer_in(timer_in));
    tic_top tic_top_inst (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_in(timer_in),
        .tin_event(tin_event), .tin_level(tin_level));
    // ====
    // bus tasks
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [23:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    // swing all pins, gather events and look at levels
    task automatic swing(input logic v, input logic [23:9] ee,
        input logic [23:9] el);
        logic [23:9] acc;
        acc = 15'h0000;
        @(posedge core_clk);
        pin_cmd <= {15{v}};
        repeat (6) begin
            @(negedge core_clk);
            acc = acc | tin_event;
        end
        `CHK("tin_event", ee, acc)
        `CHK("tin_level", el, tin_level)
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ====
    // main sequence
    initial begin
        logic [23:0] a;
        logic [23:9] m;
        int sh;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(tic_pkg::OFS_CTRL_B, 16'h0000);
        rd(tic_pkg::OFS_CTRL_C, 16'h0000);
        rd(tic_pkg::OFS_CTRL_D, 16'h0000);
        wr(tic_pkg::OFS_CTRL_B, 16'hFFFF);
        rd(tic_pkg::OFS_CTRL_B, 16'hEEE0);
        wr(tic_pkg::OFS_CTRL_C, 16'hA5C3);
        rd(tic_pkg::OFS_CTRL_C, 16'hA5C3);
        wr(tic_pkg::OFS_CTRL_D, 16'hFFFF);
        rd(tic_pkg::OFS_CTRL_D, 16'hFF00);
        wr(24'h80021A, 16'hFFFF);
        rd(24'h80021A, 16'h0000);
        wr(tic_pkg::OFS_CTRL_B, 16'h0000);
        wr(tic_pkg::OFS_CTRL_C, 16'h0000);
        wr(tic_pkg::OFS_CTRL_D, 16'h0000);
        for (int n = 9; n <= 23; n++) begin
            a = n <= 11 ? tic_pkg::OFS_CTRL_B : n <= 19 ?
                tic_pkg::OFS_CTRL_C : tic_pkg::OFS_CTRL_D;
            sh = n <= 11 ? 5 + 4 * (11 - n) : n <= 19 ? 2 * (19 - n)
                : 8 + 2 * (23 - n);
            m = 15'h0000;
            m[n] = 1'b1;
            for (int c = 0; c < (n <= 11 ? 8 : 4); c++) begin
                wr(a, 16'(c) << sh);
                swing(1'b1, (c == 1 || c == 3) ? m : 15'h0000,
                    (n <= 11 && c >= 6) ? m : 15'h0000);
                swing(1'b0, (c == 2 || c == 3) ? m : 15'h0000,
                    (n <= 11 && c / 2 == 2) ? m : 15'h0000);
                wr(a, 16'h0000);
            end
        end
        rd(tic_pkg::OFS_PIN_STAT, 16'h0000);
        swing(1'b1, 15'h0000, 15'h0000);
        rd(tic_pkg::OFS_PIN_STAT, 16'hFFFE);
        end_of_test();
    end
endmodule
